/* File: design/adc_clip_limit_irq.sv */
// Clip and limit event flags, enables, pending views and converter interrupt
`default_nettype none
module adc_clip_limit_irq (
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_strobe,
  input  wire logic        rd_strobe,
  output logic      [31:0] rd_data,
  // Sequencer results
  input  wire logic        raw_valid,
  input  wire logic [3:0]  raw_chan,
  input  wire logic [11:0] raw_result,
  input  wire logic [1:0]  raw_res,
  input  wire logic        avg_valid,
  input  wire logic [3:0]  avg_chan,
  input  wire logic [15:0] avg_result,
  // Main interrupt flags and their masks
  input  wire logic [7:0]  main_flags,
  input  wire logic [7:0]  main_mask,
  // Outputs
  output logic      [15:0] clip_flag_mirror,
  output logic      [15:0] limit_flag_mirror,
  output logic             irq
);
  logic [11:0] active_bits;
  logic [11:0] raw_active;
  logic        clip_hit;
  logic [15:0] clip_set;
  logic        below_low;
  logic        at_or_above_high;
  logic        limit_hit;
  logic [15:0] limit_set;
  logic [1:0]  cmp_mode_r;
  logic [15:0] limit_low_r;
  logic [15:0] limit_high_r;
  logic [15:0] clip_flags;
  logic [15:0] clip_enable;
  logic [15:0] clip_pend;
  logic [15:0] limit_flags;
  logic [15:0] limit_enable;
  logic [15:0] limit_pend;
  logic        clip_clr_wr;
  logic        clip_en_wr;
  logic        limit_clr_wr;
  logic        limit_en_wr;
  logic        irq_nxt;
  logic        irq_r;
  logic [31:0] rd_data_nxt;
  logic [31:0] rd_data_r;

  // Clip detection on the raw result
  always_comb begin
    unique case (raw_res)
      clip_limit_pkg::RES_10: active_bits = clip_limit_pkg::ACT_10;
      clip_limit_pkg::RES_8:  active_bits = clip_limit_pkg::ACT_8;
      default:                active_bits = clip_limit_pkg::ACT_12;
    endcase
  end

  assign raw_active = raw_result & active_bits;

  // Upper unused bits are forced to zero, so all-ones compares to the mask itself
  assign clip_hit = (raw_active == 12'h000) || (raw_active == active_bits);

  assign clip_set = raw_valid && clip_hit ? (16'h0001 << raw_chan) : 16'h0000;

  // Limit detection on the averaged result
  assign below_low        = avg_result < limit_low_r;
  assign at_or_above_high = avg_result >= limit_high_r;

  always_comb begin
    unique case (cmp_mode_r)
      clip_limit_pkg::CMP_BELOW:  limit_hit = below_low;
      clip_limit_pkg::CMP_INSIDE: limit_hit = !below_low && !at_or_above_high;
      clip_limit_pkg::CMP_ABOVE:  limit_hit = at_or_above_high;
      clip_limit_pkg::CMP_OUTSIDE: limit_hit = below_low || at_or_above_high;
    endcase
  end

  assign limit_set = avg_valid && limit_hit ? (16'h0001 << avg_chan) : 16'h0000;

  // Register write decode
  assign clip_clr_wr  = wr_strobe && (addr == clip_limit_pkg::CLIP_REQ_OFS);
  assign clip_en_wr   = wr_strobe && (addr == clip_limit_pkg::CLIP_EN_OFS);
  assign limit_clr_wr = wr_strobe && (addr == clip_limit_pkg::LIMIT_REQ_OFS);
  assign limit_en_wr  = wr_strobe && (addr == clip_limit_pkg::LIMIT_EN_OFS);

  // Clip flags; the bank keeps a set that collides with a clear
  event_flag_bank #(
    .EN_RESET (clip_limit_pkg::CLIP_EN_RST)
  ) u_clip_bank (
    .clk      (clk),
    .reset    (reset),
    .set_vec  (clip_set),
    .clr_wr   (clip_clr_wr),
    .clr_data (wr_data[15:0]),
    .en_wr    (clip_en_wr),
    .en_data  (wr_data[15:0]),
    .flags_r  (clip_flags),
    .enable_r (clip_enable),
    .pending  (clip_pend)
  );

  event_flag_bank #(
    .EN_RESET (clip_limit_pkg::LIMIT_EN_RST)
  ) u_limit_bank (
    .clk      (clk),
    .reset    (reset),
    .set_vec  (limit_set),
    .clr_wr   (limit_clr_wr),
    .clr_data (wr_data[15:0]),
    .en_wr    (limit_en_wr),
    .en_data  (wr_data[15:0]),
    .flags_r  (limit_flags),
    .enable_r (limit_enable),
    .pending  (limit_pend)
  );

  // Comparison configuration
  always_ff @(posedge clk) begin
    if (reset) begin
      cmp_mode_r <= clip_limit_pkg::CMP_MODE_RST;
    end else if (wr_strobe && (addr == clip_limit_pkg::CMP_MODE_OFS)) begin
      cmp_mode_r <= wr_data[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      limit_low_r <= clip_limit_pkg::LIMIT_LOW_RST;
    end else if (wr_strobe && (addr == clip_limit_pkg::LIMIT_LOW_OFS)) begin
      limit_low_r <= wr_data[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      limit_high_r <= clip_limit_pkg::LIMIT_HIGH_RST;
    end else if (wr_strobe && (addr == clip_limit_pkg::LIMIT_HIGH_OFS)) begin
      limit_high_r <= wr_data[15:0];
    end
  end

  // Read mux; data stand only in the cycle after the strobe
  always_comb begin
    rd_data_nxt = clip_limit_pkg::RDATA_RST;
    if (rd_strobe) begin
      unique case (addr)
        clip_limit_pkg::CLIP_REQ_OFS:   rd_data_nxt = {16'h0000, clip_flags};
        clip_limit_pkg::CLIP_EN_OFS:    rd_data_nxt = {16'h0000, clip_enable};
        clip_limit_pkg::CLIP_PEND_OFS:  rd_data_nxt = {16'h0000, clip_pend};
        clip_limit_pkg::LIMIT_REQ_OFS:  rd_data_nxt = {16'h0000, limit_flags};
        clip_limit_pkg::LIMIT_EN_OFS:   rd_data_nxt = {16'h0000, limit_enable};
        clip_limit_pkg::LIMIT_PEND_OFS: rd_data_nxt = {16'h0000, limit_pend};
        clip_limit_pkg::CMP_MODE_OFS:   rd_data_nxt = {30'h0, cmp_mode_r};
        clip_limit_pkg::LIMIT_LOW_OFS:  rd_data_nxt = {16'h0000, limit_low_r};
        clip_limit_pkg::LIMIT_HIGH_OFS: rd_data_nxt = {16'h0000, limit_high_r};
        default:                        rd_data_nxt = clip_limit_pkg::RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_r <= clip_limit_pkg::RDATA_RST;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;

  // Interrupt is registered so it never glitches on the input compare paths
  assign irq_nxt = (|clip_pend) || (|limit_pend) || (|(main_flags & main_mask));

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  assign irq = irq_r;

  assign clip_flag_mirror  = clip_flags;
  assign limit_flag_mirror = limit_flags;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  clip_full_a: assert property (
    raw_valid && (raw_res == clip_limit_pkg::RES_12) && (raw_result == 12'hfff)
    |=> clip_flags[$past(raw_chan)])
    else $error("clip flag not set on full-scale result");

  clip_zero_a: assert property (
    raw_valid && (raw_result == 12'h000) |=> clip_flags[$past(raw_chan)])
    else $error("clip flag not set on zero result");

  clip_res8_a: assert property (
    raw_valid && (raw_res == clip_limit_pkg::RES_8) && (raw_result[7:0] == 8'hff)
    |=> clip_flags[$past(raw_chan)])
    else $error("8-bit clip ignored active bits");

  clip_midscale_a: assert property (
    raw_valid && (raw_res == clip_limit_pkg::RES_10) && (raw_result[9:0] != 10'h000)
    && (raw_result[9:0] != 10'h3ff) && !clip_flags[raw_chan]
    |=> !clip_flags[$past(raw_chan)])
    else $error("clip flag set on mid-scale result");

  w1c_clear_a: assert property (
    clip_clr_wr && wr_data[0] && !clip_set[0] |=> !clip_flags[0])
    else $error("write one did not clear clip flag");

  w0_keep_a: assert property (
    limit_clr_wr && !wr_data[3] && limit_flags[3] |=> limit_flags[3])
    else $error("write zero cleared limit flag");

  limit_set_a: assert property (
    avg_valid && (cmp_mode_r == clip_limit_pkg::CMP_ABOVE) && (avg_result >= limit_high_r)
    |=> limit_flags[$past(avg_chan)])
    else $error("limit flag not set on compare hit");

  clip_enable_a: assert property (
    clip_en_wr |=> clip_enable == $past(wr_data[15:0]))
    else $error("clip enable did not take write");

  limit_enable_a: assert property (
    limit_en_wr |=> limit_enable == $past(wr_data[15:0]))
    else $error("limit enable did not take write");

  clip_pending_a: assert property (
    rd_strobe && (addr == clip_limit_pkg::CLIP_PEND_OFS)
    |=> rd_data == {16'h0000, $past(clip_flags) & $past(clip_enable)})
    else $error("clip pending read wrong");

  limit_pending_a: assert property (
    rd_strobe && (addr == clip_limit_pkg::LIMIT_PEND_OFS)
    |=> rd_data == {16'h0000, $past(limit_flags) & $past(limit_enable)})
    else $error("limit pending read wrong");

  irq_level_a: assert property (
    ((clip_flags & clip_enable) != 16'h0000) || ((limit_flags & limit_enable) != 16'h0000)
    |=> irq)
    else $error("interrupt missing with pending event");

  main_irq_a: assert property (
    (main_flags & main_mask) != 8'h00 |=> irq)
    else $error("interrupt missing with masked main flag");

  irq_quiet_a: assert property (
    (clip_pend == 16'h0000) && (limit_pend == 16'h0000)
    && ((main_flags & main_mask) == 8'h00) |=> !irq)
    else $error("interrupt high with nothing pending");

  mirror_bits_a: assert property (
    avg_valid && (cmp_mode_r == clip_limit_pkg::CMP_BELOW) && (avg_result < limit_low_r)
    |=> limit_flag_mirror[$past(avg_chan)])
    else $error("limit mirror did not follow flag");

  set_wins_a: assert property (
    clip_set[4] && clip_clr_wr && wr_data[4] |=> clip_flags[4])
    else $error("set lost to simultaneous clear");

  unmapped_read_a: assert property (
    rd_strobe && (addr == 8'h40) |=> rd_data == 32'h0000_0000)
    else $error("unmapped read not zero");

  cover_clip_irq: cover property (raw_valid && clip_hit ##1 clip_pend != 16'h0000 ##1 irq);

  cover_limit_irq: cover property (avg_valid && limit_hit ##2 irq);

  cover_collide: cover property (clip_set != 16'h0000 && clip_clr_wr);

  cover_clear_drop: cover property (irq ##1 clip_clr_wr ##2 !irq);
endmodule
`default_nettype wire

/* File: design/event_flag_bank.sv */
// Sixteen sticky event flags with write-one-to-clear and an enable bank
`default_nettype none
module event_flag_bank #(
  parameter logic [15:0] EN_RESET = 16'h0000
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [15:0] set_vec,
  input  wire logic        clr_wr,
  input  wire logic [15:0] clr_data,
  input  wire logic        en_wr,
  input  wire logic [15:0] en_data,
  output logic      [15:0] flags_r,
  output logic      [15:0] enable_r,
  output logic      [15:0] pending
);
  logic [15:0] flags_nxt;

  // Set wins over a clear landing in the same cycle
  always_comb begin
    flags_nxt = flags_r;
    if (clr_wr) begin
      flags_nxt = flags_nxt & ~clr_data;
    end
    flags_nxt = flags_nxt | set_vec;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_r <= clip_limit_pkg::FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      enable_r <= EN_RESET;
    end else if (en_wr) begin
      enable_r <= en_data;
    end
  end

  assign pending = flags_r & enable_r;
endmodule
`default_nettype wire

/* File: inc/clip_limit_pkg.sv */
// Constants shared by the clip and limit event interrupt block
`default_nettype none
package clip_limit_pkg;
  localparam int          CHAN_N         = 16;
  localparam int          CHAN_W         = 4;
  localparam int          RAW_W          = 12;
  localparam int          AVG_W          = 16;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          MAIN_W         = 8;

  // Register byte addresses
  localparam logic [7:0]  CLIP_REQ_OFS   = 8'h00;
  localparam logic [7:0]  CLIP_EN_OFS    = 8'h04;
  localparam logic [7:0]  CLIP_PEND_OFS  = 8'h08;
  localparam logic [7:0]  LIMIT_REQ_OFS  = 8'h0c;
  localparam logic [7:0]  LIMIT_EN_OFS   = 8'h10;
  localparam logic [7:0]  LIMIT_PEND_OFS = 8'h14;
  localparam logic [7:0]  CMP_MODE_OFS   = 8'h18;
  localparam logic [7:0]  LIMIT_LOW_OFS  = 8'h1c;
  localparam logic [7:0]  LIMIT_HIGH_OFS = 8'h20;

  // Resolution codes delivered with each raw result
  localparam logic [1:0]  RES_12         = 2'h0;
  localparam logic [1:0]  RES_10         = 2'h1;
  localparam logic [1:0]  RES_8          = 2'h2;
  localparam logic [11:0] ACT_12         = 12'hfff;
  localparam logic [11:0] ACT_10         = 12'h3ff;
  localparam logic [11:0] ACT_8          = 12'h0ff;

  // Comparison rules for the limit event
  localparam logic [1:0]  CMP_BELOW      = 2'h0;
  localparam logic [1:0]  CMP_INSIDE     = 2'h1;
  localparam logic [1:0]  CMP_ABOVE      = 2'h2;
  localparam logic [1:0]  CMP_OUTSIDE    = 2'h3;

  // Values after reset
  localparam logic [15:0] CLIP_EN_RST    = 16'hffff;
  localparam logic [15:0] LIMIT_EN_RST   = 16'h0000;
  localparam logic [1:0]  CMP_MODE_RST   = 2'h0;
  localparam logic [15:0] LIMIT_LOW_RST  = 16'h0000;
  localparam logic [15:0] LIMIT_HIGH_RST = 16'hffff;
  localparam logic [15:0] FLAGS_RST      = 16'h0000;
  localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

  // Mirror positions in each channel result word
  localparam int          MIRROR_CLIP_BIT  = 29;
  localparam int          MIRROR_LIMIT_BIT = 30;
endpackage
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for the clip and limit event interrupt block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        reset;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_strobe;
  logic        rd_strobe;
  logic [31:0] rd_data;
  logic        raw_valid;
  logic [3:0]  raw_chan;
  logic [11:0] raw_result;
  logic [1:0]  raw_res;
  logic        avg_valid;
  logic [3:0]  avg_chan;
  logic [15:0] avg_result;
  logic [7:0]  main_flags;
  logic [7:0]  main_mask;
  logic [15:0] clip_flag_mirror;
  logic [15:0] limit_flag_mirror;
  logic        irq;
  logic [15:0] exp_flags;
  int          errors;
  int          tests_run;
  // Clip probes: channel, raw value and resolution code per entry
  int          cc [12] = '{3, 5, 6, 0, 1, 2, 7, 8, 9, 10, 11, 12};
  logic [11:0] cv [12] = '{12'hfff, 12'h000, 12'h7ff, 12'hc00, 12'h3ff, 12'h5ff,
                           12'h0ff, 12'h3ff, 12'h1fe, 12'h3ff, 12'h000, 12'hc01};
  logic [1:0]  cr [12] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2,
                           2'h0, 2'h2, 2'h2, 2'h3, 2'h2, 2'h1};
  // Averaged probes straddle both limit boundaries (low 0x100, high 0x200)
  logic [15:0] lv [4] = '{16'h00ff, 16'h0100, 16'h01ff, 16'h0200};

  adc_clip_limit_irq i_adc_clip_limit_irq (
    .clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .raw_valid(raw_valid), .raw_chan(raw_chan),
    .raw_result(raw_result), .raw_res(raw_res), .avg_valid(avg_valid), .avg_chan(avg_chan),
    .avg_result(avg_result), .main_flags(main_flags), .main_mask(main_mask),
    .clip_flag_mirror(clip_flag_mirror), .limit_flag_mirror(limit_flag_mirror), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic clip_hit(input logic [11:0] v, input logic [1:0] res);
    logic [11:0] act;
    act = (res == clip_limit_pkg::RES_10) ? clip_limit_pkg::ACT_10
        : (res == clip_limit_pkg::RES_8)  ? clip_limit_pkg::ACT_8 : clip_limit_pkg::ACT_12;
    return ((v & act) == 12'h000) || ((v & act) == act);
  endfunction

  function automatic logic lim_hit(input logic [1:0] m, input logic [15:0] v);
    logic lo;
    logic hi;
    lo = v < 16'h0100;
    hi = v >= 16'h0200;
    case (m)
      clip_limit_pkg::CMP_BELOW:  return lo;
      clip_limit_pkg::CMP_INSIDE: return !lo && !hi;
      clip_limit_pkg::CMP_ABOVE:  return hi;
      default:                    return lo || hi;
    endcase
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  // Strobes drop at the taking edge, so back-to-back calls leave one idle cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_strobe <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    @(posedge clk);
    rd_strobe <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 chk(rd_data, want);
  endtask

  task automatic raw(input logic [3:0] c, input logic [11:0] v, input logic [1:0] res);
    @(posedge clk);
    raw_valid <= 1'b1;
    raw_chan <= c;
    raw_result <= v;
    raw_res <= res;
    @(posedge clk);
    raw_valid <= 1'b0;
  endtask

  task automatic avg(input logic [3:0] c, input logic [15:0] v);
    @(posedge clk);
    avg_valid <= 1'b1;
    avg_chan <= c;
    avg_result <= v;
    @(posedge clk);
    avg_valid <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    {reset, wr_strobe, rd_strobe, raw_valid, avg_valid} = 5'h10;
    {addr, wr_data, raw_chan, raw_result, raw_res} = '0;
    {avg_chan, avg_result, main_flags, main_mask} = '0;
    errors = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd_chk(clip_limit_pkg::CLIP_EN_OFS, 32'h0000_ffff);
    rd_chk(clip_limit_pkg::LIMIT_EN_OFS, 32'h0);
    rd_chk(clip_limit_pkg::CLIP_REQ_OFS, 32'h0);
    rd_chk(clip_limit_pkg::LIMIT_HIGH_OFS, {16'h0, clip_limit_pkg::LIMIT_HIGH_RST});
    rd_chk(8'h40, 32'h0);
    $display("done: reset values");
    exp_flags = 16'h0000;
    for (int i = 0; i < 12; i++) begin
      raw(4'(cc[i]), cv[i], cr[i]);
      if (clip_hit(cv[i], cr[i])) exp_flags[cc[i]] = 1'b1;
    end
    rd_chk(clip_limit_pkg::CLIP_REQ_OFS, {16'h0, exp_flags});
    chk({16'h0, clip_flag_mirror}, {16'h0, exp_flags});
    rd_chk(clip_limit_pkg::CLIP_PEND_OFS, {16'h0, exp_flags});
    chk({31'h0, irq}, 32'h1);
    $display("done: clip detection");
    wr(clip_limit_pkg::CLIP_EN_OFS, 32'hffff_0003);
    rd_chk(clip_limit_pkg::CLIP_EN_OFS, 32'h0000_0003);
    rd_chk(clip_limit_pkg::CLIP_PEND_OFS, {16'h0, exp_flags & 16'h0003});
    wr(clip_limit_pkg::CLIP_EN_OFS, 32'h0000_0010);
    wr(clip_limit_pkg::CLIP_REQ_OFS, 32'h0000_0003);
    wr(clip_limit_pkg::CLIP_PEND_OFS, 32'h0000_ffff);
    rd_chk(clip_limit_pkg::CLIP_REQ_OFS, {16'h0, exp_flags & 16'hfffc});
    chk({31'h0, irq}, 32'h0);
    wr(clip_limit_pkg::CLIP_REQ_OFS, 32'h0000_ffff);
    rd_chk(clip_limit_pkg::CLIP_REQ_OFS, 32'h0);
    raw(4'h4, 12'hfff, clip_limit_pkg::RES_12);
    // New event on channel 4 in the very cycle software clears it
    @(posedge clk);
    raw_valid <= 1'b1;
    wr_strobe <= 1'b1;
    addr <= clip_limit_pkg::CLIP_REQ_OFS;
    wr_data <= 32'h0000_0010;
    @(posedge clk);
    raw_valid <= 1'b0;
    wr_strobe <= 1'b0;
    rd_chk(clip_limit_pkg::CLIP_REQ_OFS, 32'h0000_0010);
    chk({31'h0, irq}, 32'h1);
    wr(clip_limit_pkg::CLIP_REQ_OFS, 32'h0000_0010);
    $display("done: enable and clear");
    wr(clip_limit_pkg::LIMIT_LOW_OFS, 32'h0000_0100);
    wr(clip_limit_pkg::LIMIT_HIGH_OFS, 32'h0000_0200);
    wr(clip_limit_pkg::LIMIT_EN_OFS, 32'h0000_0009);
    rd_chk(clip_limit_pkg::LIMIT_EN_OFS, 32'h0000_0009);
    for (int m = 0; m < 4; m++) begin
      wr(clip_limit_pkg::CMP_MODE_OFS, 32'(m));
      wr(clip_limit_pkg::LIMIT_REQ_OFS, 32'h0000_ffff);
      exp_flags = 16'h0000;
      for (int c = 0; c < 4; c++) begin
        avg(4'(c), lv[c]);
        if (lim_hit(2'(m), lv[c])) exp_flags[c] = 1'b1;
      end
      rd_chk(clip_limit_pkg::LIMIT_REQ_OFS, {16'h0, exp_flags});
      chk({16'h0, limit_flag_mirror}, {16'h0, exp_flags});
      rd_chk(clip_limit_pkg::LIMIT_PEND_OFS, {16'h0, exp_flags & 16'h0009});
      chk({31'h0, irq}, {31'h0, |(exp_flags & 16'h0009)});
    end
    // Outside mode left flags 0 and 3; clearing only flag 0 must keep flag 3
    wr(clip_limit_pkg::LIMIT_REQ_OFS, 32'h0000_0001);
    rd_chk(clip_limit_pkg::LIMIT_REQ_OFS, 32'h0000_0008);
    wr(clip_limit_pkg::LIMIT_REQ_OFS, 32'h0000_ffff);
    $display("done: limit modes");
    main_flags <= 8'h24;
    main_mask <= 8'h03;
    repeat (3) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h0);
    @(posedge clk);
    main_mask <= 8'h04;
    repeat (3) @(posedge clk);
    #1 chk({31'h0, irq}, 32'h1);
    $display("done: main interrupt");
    tally_and_finish();
  end
endmodule
`default_nettype wire
